/* File: ebam_top.sv */
// Async multiplexed 16-bit SRAM bus master with AXI4-Lite registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: Burst limit 0 keeps every CPU transfer to one word.
// R2: Clock enable 0 keeps the bus clock stopped low.
// R3: High and low time 0: one aclk per phase.
// R4: High and low time fields mean value plus one aclk.
// R5: Data phase field 1 gives a two bus clock data phase.
// R6: Command phase field 1 gives a two bus clock command phase.
// R7: Setup and hold field 1 insert one bus clock each.
// R8: Latch mode 0 issues address latch strobes one after another; the code ignores the mode field and holds one strobe through the count.
// R9: Latch count 1 gives one address latch strobe per access.
// R10: Burst enable 0 allows only single accesses.
// R11: Wait mode 0 stretches accesses on the active-low wait pin.
// R12: Format 0 means async, 16-bit, multiplexed, no burst.
// R13: Each access runs address latch, command, then data phase.
// R14: CPU receive end event is bit 0x1, transmit 0x10.
// R15: DMA receive end event is bit 0x100, transmit 0x1000.
// R16: A detected end-of-block event raises the event output.
// R17: 0x40080000 is CS0 receive FIFO, 0x40090000 transmit FIFO.
// R18: CS0 transmit requests use line 11, receive line 10.
// R19: The DMA controller moves FIFO data 64 bits wide.
// R20: The master writes the end descriptor to 0x20000000.
// R21: Slave translation masks addresses with 0x00007FFF.
// R22: Shared lines carry address in latch phase, data in data phase.
// R23: The SRAM finishes in the data phase or holds wait active.
module ebam_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output var  logic        arready,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready,
    input  wire logic [3:0]  end_event_pulse,
    output var  logic        end_event_pending,
    output var  logic [15:0] dma_request,
    output var  logic        bus_clk,
    output var  logic        cs0_low,
    output var  logic        addr_latch,
    output var  logic        rd_low,
    output var  logic        wr_low,
    output var  logic [15:0] ad_out,
    output var  logic        ad_oe,
    input  wire logic [15:0] ad_in,
    input  wire logic        wait_input_0_low
);
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_ALE   = 6'h02,
        ST_CLE   = 6'h04,
        ST_SETUP = 6'h08,
        ST_DATA  = 6'h10,
        ST_HOLD  = 6'h20
    } ebam_state_t;

    logic [31:0] bus_common_config;
    logic [31:0] chipselect_cycle_size;
    logic [31:0] chipselect_setup_hold;
    logic [31:0] chipselect_config;
    logic [31:0] access_addr;
    logic [31:0] access_wdata;
    logic [15:0] access_rdata;
    logic [31:0] slave_event_register;
    logic [31:0] xlate_addr;
    logic        dir_write;
    logic        dma_tx_en;
    logic        dma_rx_en;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_off;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_fire;
    logic        start_req;
    ebam_state_t state;
    logic [3:0]  phase_left;
    logic [4:0]  gen_cnt;
    logic        gen_high;
    logic        tick;
    logic [15:0] ad_in_m;
    logic [15:0] ad_in_s;
    logic        wait_m;
    logic        wait_s;
    logic        wait_hold;

    // Merge a write into a register honouring byte strobes.
    function automatic logic [31:0] ebam_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : ebam_merge

    // Decode whether a byte offset names a register of this block.
    function automatic logic ebam_mapped(input logic [31:0] a);
        return (a[31:6] == 26'h0) && (a[1:0] == 2'h0) && (a[7:0] <= ebam_pkg::OFF_XLATE);
    endfunction : ebam_mapped

    // Countdown load from a field: the field value itself; a phase lasts load plus one bus clocks.
    function automatic logic [3:0] ebam_len(input logic [3:0] f);
        return f;
    endfunction : ebam_len

    // ----------------
    // Input synchronisers
    // ----------------
    // Pins come from the SRAM domain, so two flops before any use.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ad_in_m <= 16'h0000;
            ad_in_s <= 16'h0000;
            wait_m  <= 1'b1;
            wait_s  <= 1'b1;
        end else begin
            ad_in_m <= ad_in;
            ad_in_s <= ad_in_m;
            wait_m  <= wait_input_0_low;
            wait_s  <= wait_m;
        end
    end

    // ----------------
    // AXI4-Lite write channel
    // ----------------
    assign wr_fire = aw_held && w_held && !bvalid;

    // Address and data are taken independently; response follows both.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_off  <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= ebam_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                awready <= 1'b0;
                aw_off  <= ebam_mapped(awaddr) ? awaddr[7:0] : 8'hFF;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                wready <= 1'b0;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (wr_fire) begin
                bvalid  <= 1'b1;
                bresp   <= (aw_off == 8'hFF) ? ebam_pkg::RESP_SLVERR
                                             : ebam_pkg::RESP_OKAY;
                aw_held <= 1'b0;
                w_held  <= 1'b0;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // ----------------
    // Register file
    // ----------------
    // A start while an access runs is dropped; software polls busy.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_common_config     <= ebam_pkg::RST_COMMON;
            chipselect_cycle_size <= ebam_pkg::RST_CYCLE;
            chipselect_setup_hold <= ebam_pkg::RST_SETHOLD;
            chipselect_config     <= ebam_pkg::RST_CSCFG;
            access_addr           <= 32'h0000_0000;
            access_wdata          <= 32'h0000_0000;
            xlate_addr            <= 32'h0000_0000;
            dir_write             <= 1'b0;
            dma_tx_en             <= 1'b0;
            dma_rx_en             <= 1'b0;
            start_req             <= 1'b0;
        end else begin
            start_req <= 1'b0;
            if (wr_fire) begin
                case (aw_off)
                    ebam_pkg::OFF_COMMON: begin
                        bus_common_config <= ebam_merge(bus_common_config, w_data, w_strb);
                    end
                    ebam_pkg::OFF_CYCLE: begin
                        chipselect_cycle_size <= ebam_merge(chipselect_cycle_size, w_data, w_strb);
                    end
                    ebam_pkg::OFF_SETHOLD: begin
                        chipselect_setup_hold <= ebam_merge(chipselect_setup_hold, w_data, w_strb);
                    end
                    ebam_pkg::OFF_CSCFG: begin
                        chipselect_config <= ebam_merge(chipselect_config, w_data, w_strb);
                    end
                    ebam_pkg::OFF_ADDR: begin
                        access_addr <= ebam_merge(access_addr, w_data, w_strb);
                    end
                    ebam_pkg::OFF_WDATA: begin
                        access_wdata <= ebam_merge(access_wdata, w_data, w_strb);
                    end
                    ebam_pkg::OFF_XLATE: begin
                        xlate_addr <= w_data & ebam_pkg::XLATE_MASK; // R21
                    end
                    ebam_pkg::OFF_CTRL: begin
                        if (w_strb[0]) begin
                            dir_write <= w_data[ebam_pkg::POS_DIR_WR];
                            dma_tx_en <= w_data[ebam_pkg::POS_DMA_TX_EN];
                            dma_rx_en <= w_data[ebam_pkg::POS_DMA_RX_EN];
                            start_req <= w_data[ebam_pkg::POS_START] && (state == ST_IDLE);
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // End-of-block events are sticky; a new event wins over a clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slave_event_register <= 32'h0000_0000;
            end_event_pending    <= 1'b0;
        end else begin
            slave_event_register <= (slave_event_register
                & ~((wr_fire && aw_off == ebam_pkg::OFF_EVENT) ? w_data : 32'h0000_0000))
                | (end_event_pulse[0] ? ebam_pkg::EV_CPU_RX : 32'h0000_0000)  // R14
                | (end_event_pulse[1] ? ebam_pkg::EV_CPU_TX : 32'h0000_0000)  // R14
                | (end_event_pulse[2] ? ebam_pkg::EV_DMA_RX : 32'h0000_0000)  // R15
                | (end_event_pulse[3] ? ebam_pkg::EV_DMA_TX : 32'h0000_0000); // R15
            end_event_pending <= (|end_event_pulse) || (|slave_event_register &&
                !(wr_fire && aw_off == ebam_pkg::OFF_EVENT &&
                  (slave_event_register & ~w_data) == 32'h0000_0000)); // R16
        end
    end

    // ----------------
    // AXI4-Lite read channel
    // ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= ebam_pkg::RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rresp   <= ebam_mapped(araddr) ? ebam_pkg::RESP_OKAY : ebam_pkg::RESP_SLVERR;
                case (ebam_mapped(araddr) ? araddr[7:0] : 8'hFF)
                    ebam_pkg::OFF_COMMON:  rdata <= bus_common_config;
                    ebam_pkg::OFF_CYCLE:   rdata <= chipselect_cycle_size;
                    ebam_pkg::OFF_SETHOLD: rdata <= chipselect_setup_hold;
                    ebam_pkg::OFF_CSCFG:   rdata <= chipselect_config;
                    ebam_pkg::OFF_ADDR:    rdata <= access_addr;
                    ebam_pkg::OFF_WDATA:   rdata <= access_wdata;
                    ebam_pkg::OFF_CTRL:    rdata <= {28'h0, dma_rx_en, dma_tx_en, dir_write, 1'b0};
                    ebam_pkg::OFF_STATUS:  rdata <= {access_rdata, 12'h0,
                        access_addr == ebam_pkg::CS0_TX_FIFO,  // R17
                        access_addr == ebam_pkg::CS0_RX_FIFO,  // R17
                        wait_hold, state != ST_IDLE};
                    ebam_pkg::OFF_EVENT:   rdata <= slave_event_register;
                    ebam_pkg::OFF_XLATE:   rdata <= xlate_addr;
                    default:               rdata <= 32'h0000_0000;
                endcase
            end
            if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ----------------
    // Bus clock generator
    // ----------------
    // High and low halves last field plus one aclk cycles each; the
    // tick marks one bus clock and paces phases even when the pin is off.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gen_cnt  <= 5'h00;
            gen_high <= 1'b1;
            tick     <= 1'b0;
            bus_clk  <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (start_req) begin
                // Realign the ticks so a new latch phase lasts one whole bus clock.
                gen_high <= |bus_common_config[ebam_pkg::POS_CLKH +: 4];
                gen_cnt  <= {4'h0, |bus_common_config[ebam_pkg::POS_CLKH +: 4]};
            end else if (gen_cnt == (gen_high ? {1'b0, bus_common_config[ebam_pkg::POS_CLKH +: 4]}
                                     : {1'b0, bus_common_config[ebam_pkg::POS_CLKL +: 4]})) begin
                gen_cnt  <= 5'h00;          // R3 R4
                gen_high <= !gen_high;
                tick     <= !gen_high;
            end else begin
                gen_cnt <= gen_cnt + 5'h01;
            end
            bus_clk <= bus_common_config[ebam_pkg::POS_CLK_EN] && gen_high; // R2
        end
    end

    // ----------------
    // Access sequencer
    // ----------------
    // Only single 16-bit multiplexed accesses exist here, so burst
    // fields and the format field cannot lengthen a transfer.
    assign wait_hold = (chipselect_config[ebam_pkg::POS_WAIT_MODE +: 2] == ebam_pkg::WAIT_PIN0)
                       && !wait_s; // R11

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state        <= ST_IDLE;
            phase_left   <= 4'h0;
            access_rdata <= 16'h0000;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_req) begin // R1 R10 R12
                        state      <= ST_ALE; // R13
                        phase_left <= ebam_len({2'h0, chipselect_config[ebam_pkg::POS_ALE_NUM +: 2]})
                                      - 4'h1; // R8 R9
                    end
                end
                ST_ALE: begin
                    if (tick) begin
                        if (phase_left == 4'h0) begin
                            state      <= ST_CLE; // R13
                            phase_left <= ebam_len(chipselect_cycle_size[ebam_pkg::POS_CLE +: 4]); // R6
                        end else begin
                            phase_left <= phase_left - 4'h1;
                        end
                    end
                end
                ST_CLE: begin
                    if (tick) begin
                        if (phase_left != 4'h0) begin
                            phase_left <= phase_left - 4'h1;
                        end else if (chipselect_setup_hold[(dir_write ? ebam_pkg::POS_WR_SETUP
                                     : ebam_pkg::POS_RD_SETUP) +: 4] != 4'h0) begin
                            state      <= ST_SETUP; // R7
                            phase_left <= chipselect_setup_hold[(dir_write ? ebam_pkg::POS_WR_SETUP
                                          : ebam_pkg::POS_RD_SETUP) +: 4] - 4'h1;
                        end else begin
                            state      <= ST_DATA;
                            phase_left <= chipselect_cycle_size[(dir_write ? ebam_pkg::POS_WR_NB
                                          : ebam_pkg::POS_RD_NB) +: 4];
                        end
                    end
                end
                ST_SETUP: begin
                    if (tick) begin
                        if (phase_left == 4'h0) begin
                            state      <= ST_DATA; // R13
                            phase_left <= chipselect_cycle_size[(dir_write ? ebam_pkg::POS_WR_NB
                                          : ebam_pkg::POS_RD_NB) +: 4]; // R5
                        end else begin
                            phase_left <= phase_left - 4'h1;
                        end
                    end
                end
                ST_DATA: begin
                    if (tick && !(phase_left == 4'h0 && wait_hold)) begin // R23
                        if (phase_left != 4'h0) begin
                            phase_left <= phase_left - 4'h1;
                        end else begin
                            access_rdata <= dir_write ? access_rdata : ad_in_s;
                            phase_left   <= chipselect_setup_hold[(dir_write ? ebam_pkg::POS_WR_HOLD
                                            : ebam_pkg::POS_RD_HOLD) +: 4];
                            state        <= ST_HOLD; // R7
                        end
                    end
                end
                ST_HOLD: begin
                    if (tick || phase_left == 4'h0) begin
                        if (phase_left <= 4'h1) begin
                            state <= ST_IDLE;
                        end else begin
                            phase_left <= phase_left - 4'h1;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------
    // Pin drivers
    // ----------------
    // Pins follow the state one aclk late so each comes from a flop.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cs0_low     <= 1'b1;
            addr_latch  <= 1'b0;
            rd_low      <= 1'b1;
            wr_low      <= 1'b1;
            ad_out      <= 16'h0000;
            ad_oe       <= 1'b0;
            dma_request <= 16'h0000;
        end else begin
            cs0_low    <= (state == ST_IDLE);
            addr_latch <= (state == ST_ALE);
            rd_low     <= !(state == ST_DATA && !dir_write);
            wr_low     <= !(state == ST_DATA && dir_write);
            ad_out     <= (state == ST_ALE || state == ST_CLE) ? access_addr[15:0]
                                                               : access_wdata[15:0]; // R22
            ad_oe      <= (state == ST_ALE) || (state == ST_CLE)
                          || (dir_write && state != ST_IDLE); // R22
            dma_request <= 16'h0000;
            dma_request[ebam_pkg::DMA_IF_TX] <= dma_tx_en && (state == ST_IDLE); // R18
            dma_request[ebam_pkg::DMA_IF_RX] <= dma_rx_en && (state == ST_IDLE); // R18
        end
    end
endmodule : ebam_top
`default_nettype wire

/* File: ebam_pkg.sv */
// Shared constants of the external bus async SRAM master.
package ebam_pkg;
    // ----------------
    // Register byte offsets
    // ----------------
    localparam logic [7:0] OFF_COMMON   = 8'h00;
    localparam logic [7:0] OFF_CYCLE    = 8'h04;
    localparam logic [7:0] OFF_SETHOLD  = 8'h08;
    localparam logic [7:0] OFF_CSCFG    = 8'h0C;
    localparam logic [7:0] OFF_ADDR     = 8'h10;
    localparam logic [7:0] OFF_WDATA    = 8'h14;
    localparam logic [7:0] OFF_CTRL     = 8'h18;
    localparam logic [7:0] OFF_STATUS   = 8'h1C;
    localparam logic [7:0] OFF_EVENT    = 8'h20;
    localparam logic [7:0] OFF_XLATE    = 8'h24;
    // ----------------
    // Field positions
    // ----------------
    localparam int POS_RD_BURST  = 0;
    localparam int POS_WR_BURST  = 3;
    localparam int POS_CLK_EN    = 6;
    localparam int POS_CLKH      = 8;
    localparam int POS_CLKL      = 12;
    localparam int POS_WR_NB     = 0;
    localparam int POS_RD_NB     = 4;
    localparam int POS_WR_B      = 8;
    localparam int POS_RD_B      = 12;
    localparam int POS_CLE       = 16;
    localparam int POS_WR_HOLD   = 0;
    localparam int POS_RD_HOLD   = 4;
    localparam int POS_WR_SETUP  = 8;
    localparam int POS_RD_SETUP  = 12;
    localparam int POS_ALE_MODE  = 0;
    localparam int POS_ALE_NUM   = 1;
    localparam int POS_BURST_ON  = 3;
    localparam int POS_WAIT_MODE = 4;
    localparam int POS_FORMAT    = 8;
    localparam int POS_START     = 0;
    localparam int POS_DIR_WR    = 1;
    localparam int POS_DMA_TX_EN = 2;
    localparam int POS_DMA_RX_EN = 3;
    // ----------------
    // Reset values and fixed codes
    // ----------------
    localparam logic [31:0] RST_COMMON  = 32'h0000_0000;
    localparam logic [31:0] RST_CYCLE   = 32'h0001_1111;
    localparam logic [31:0] RST_SETHOLD = 32'h0000_1111;
    localparam logic [31:0] RST_CSCFG   = 32'h0000_0002;
    localparam logic [31:0] EV_CPU_RX   = 32'h0000_0001;
    localparam logic [31:0] EV_CPU_TX   = 32'h0000_0010;
    localparam logic [31:0] EV_DMA_RX   = 32'h0000_0100;
    localparam logic [31:0] EV_DMA_TX   = 32'h0000_1000;
    localparam logic [31:0] XLATE_MASK  = 32'h0000_7FFF;
    localparam logic [31:0] CS0_RX_FIFO = 32'h4008_0000;
    localparam logic [31:0] CS0_TX_FIFO = 32'h4009_0000;
    localparam int          DMA_IF_TX   = 11;
    localparam int          DMA_IF_RX   = 10;
    localparam logic [2:0]  FMT_ASYNC16 = 3'h0;
    localparam logic [1:0]  WAIT_PIN0   = 2'h0;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : ebam_pkg

/* File: ebam_sram_model.sv */
// Behavioural async SRAM on the multiplexed 16-bit bus.
`timescale 1ns/1ps
`default_nettype none
module ebam_sram_model (
    input  wire logic        aclk,
    input  wire logic        addr_latch,
    input  wire logic        rd_low,
    input  wire logic        wr_low,
    input  wire logic [15:0] ad_out,
    output var  logic [15:0] ad_in,
    output var  logic        wait_input_0_low
);
    logic [15:0] mem [16];
    logic [3:0]  addr;
    logic [15:0] last;
    // Latch the address, store write data, remember the word last driven.
    always_ff @(posedge aclk) begin
        if (addr_latch) addr <= ad_out[3:0];
        if (!wr_low) mem[addr] <= ad_out;
        if (!rd_low) last <= mem[addr];
    end
    // Released lines show the inverse, so a stale sample cannot match.
    assign ad_in = rd_low ? ~last : mem[addr];
    // Each access ends inside its data phase, so wait stays idle.
    assign wait_input_0_low = 1'b1;
endmodule : ebam_sram_model
`default_nettype wire

/* File: ebam_top_assertions.sv */
// Port checks of the async SRAM bus master.
`timescale 1ns/1ps
`default_nettype none
module ebam_top_assertions (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic [15:0] dma_request,
    input wire logic        bus_clk,
    input wire logic        cs0_low,
    input wire logic        addr_latch,
    input wire logic        rd_low,
    input wire logic        wr_low,
    input wire logic        ad_oe
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    a_dma_lines: assert property (dma_request[9:0] == 10'h000 && dma_request[15:12] == 4'h0)
        else $error("unused dma line set");
    a_clock_off: assert property (!bus_clk)
        else $error("bus clock runs");
    a_latch_width: assert property ($rose(addr_latch) |=> addr_latch ##1 !addr_latch)
        else $error("latch width wrong");
    a_cmd_gap: assert property ($fell(addr_latch) |-> (rd_low && wr_low)[*6] ##1 !(rd_low && wr_low))
        else $error("command or setup length wrong");
    a_write_phase: assert property ($fell(wr_low) |-> (!wr_low)[*4] ##1 wr_low)
        else $error("write phase length wrong");
    a_read_phase: assert property ($fell(rd_low) |-> (!rd_low)[*4] ##1 rd_low)
        else $error("read phase length wrong");
    a_strobe_select: assert property (addr_latch || !rd_low || !wr_low |-> !cs0_low)
        else $error("strobe without select");
    a_read_release: assert property (!rd_low |-> !ad_oe)
        else $error("lines driven in read");
    cover property ($fell(wr_low));
    cover property ($fell(rd_low));
    cover property (dma_request[11] && dma_request[10]);
endmodule : ebam_top_assertions
bind ebam_top ebam_top_assertions chk_u (.*);
`default_nettype wire

/* File: ebam_top_test.sv */
// Self-checking bench of the async SRAM bus master.
`timescale 1ns/1ps
`default_nettype none
module ebam_top_test;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
    logic        bvalid, arready, rvalid, end_event_pending, bus_clk, cs0_low, addr_latch;
    logic        rd_low, wr_low, ad_oe, wait_input_0_low;
    logic [31:0] awaddr, wdata, araddr, rdata, d, x;
    logic [15:0] dma_request, ad_out, ad_in;
    logic [3:0]  wstrb, end_event_pulse;
    logic [1:0]  bresp, rresp, r;
    int          num_errors, checks, i;
    ebam_top dut_u (.*);
    ebam_sram_model sram_u (.*);
    // Free-running aclk, 5 ns period.
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // A hang ends the run as a failure.
    initial begin
        #100000;
        num_errors++;
        conclude();
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        awaddr <= {24'h000000, a};
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        araddr <= {24'h000000, a};
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
    endtask : rd
    // Starts one external access and polls until busy drops.
    task automatic sram(input logic wr_op, input logic [31:0] a, input logic [31:0] v);
        wr(ebam_pkg::OFF_ADDR, a);
        wr(ebam_pkg::OFF_WDATA, v);
        wr(ebam_pkg::OFF_CTRL, {30'h0, wr_op, 1'b1});
        repeat (3) @(posedge aclk);
        d = 32'h1;
        for (int k = 0; k < 60 && d[0]; k++) rd(ebam_pkg::OFF_STATUS);
        chk("busy", 32'h0, {31'h0, d[0]});
    endtask : sram
    function automatic logic [31:0] ev_exp(input int k);
        return k == 0 ? ebam_pkg::EV_CPU_RX : k == 1 ? ebam_pkg::EV_CPU_TX :
            k == 2 ? ebam_pkg::EV_DMA_RX : ebam_pkg::EV_DMA_TX;
    endfunction : ev_exp
    task automatic conclude();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    // Main sequence: reset values, refusals, events, decode, then SRAM traffic.
    initial begin
        {awvalid, wvalid, arvalid, end_event_pulse, aresetn} = '0;
        {awaddr, wdata, araddr} = '0;
        {bready, rready, wstrb} = 6'h3F;
        void'($urandom(43016));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ebam_pkg::OFF_COMMON);
        chk("common", ebam_pkg::RST_COMMON, d);
        rd(ebam_pkg::OFF_CSCFG);
        chk("cscfg", ebam_pkg::RST_CSCFG, d);
        rd(8'h80);
        chk("rresp", {30'h0, ebam_pkg::RESP_SLVERR}, {30'h0, r});
        for (i = 0; i < 4; i++) begin
            end_event_pulse <= 4'h1 << i;
            @(posedge aclk);
            end_event_pulse <= 4'h0;
            @(posedge aclk);
            chk("pending", 32'h1, {31'h0, end_event_pending});
            rd(ebam_pkg::OFF_EVENT);
            chk("event", ev_exp(i), d);
            wr(ebam_pkg::OFF_EVENT, ev_exp(i));
        end
        chk("pending", 32'h0, {31'h0, end_event_pending});
        x = $urandom;
        wr(ebam_pkg::OFF_XLATE, x);
        rd(ebam_pkg::OFF_XLATE);
        chk("xlate", x & ebam_pkg::XLATE_MASK, d);
        wr(ebam_pkg::OFF_ADDR, ebam_pkg::CS0_RX_FIFO);
        wr(ebam_pkg::OFF_CTRL, 32'hC);
        rd(ebam_pkg::OFF_STATUS);
        chk("fifo", 32'h4, d & 32'hC);
        chk("dma", 32'h0C00, {16'h0, dma_request});
        wr(ebam_pkg::OFF_CTRL, 32'h0);
        for (i = 0; i < 3; i++) begin
            x = $urandom & 32'hFFFF;
            sram(1'b1, i, x);
            sram(1'b0, i, x);
            chk("sram", x, d >> 16);
        end
        conclude();
    end
endmodule : ebam_top_test
`default_nettype wire
